// ==== bseu_defines.svh ====
// Constants of the branch, skip and bit execution unit
`ifndef BSEU_DEFINES_SVH
`define BSEU_DEFINES_SVH

// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define BSEU_FLAG_C 0
`define BSEU_FLAG_Z 1
`define BSEU_FLAG_N 2
`define BSEU_FLAG_V 3
`define BSEU_FLAG_S 4
`define BSEU_FLAG_H 5
`define BSEU_FLAG_T 6
`define BSEU_FLAG_I 7

// ----------------------------------------------------------------
// Widths and operand bit positions
// ----------------------------------------------------------------
`define BSEU_DATA_W 8
`define BSEU_ADDR_W 16
`define BSEU_IO_W 5
`define BSEU_OFS_W 7
`define BSEU_MSB 7
`define BSEU_NIB_MSB 3

// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define BSEU_CYC_ONE 1
`define BSEU_CYC_JUMP 2
`define BSEU_CYC_CALL 3
`define BSEU_CYC_IO_BIT 2
`define BSEU_CYC_BR_TAKEN 2
`define BSEU_CYC_SKIP_ONE 2
`define BSEU_CYC_SKIP_TWO 3

// ----------------------------------------------------------------
// Program counter steps and byte constants
// ----------------------------------------------------------------
`define BSEU_PC_STEP 16'h0001
`define BSEU_SKIP_ONE_STEP 16'h0002
`define BSEU_SKIP_TWO_STEP 16'h0003
`define BSEU_BYTE_ZERO 8'h00
`define BSEU_BIT_ONE 8'h01

`endif

// ==== bseu_pkg.sv ====
// Types and helper functions of the branch, skip and bit execution unit
`include "bseu_defines.svh"

package bseu_pkg;

  // Decoded operation of this instruction group
  typedef enum logic [4:0] {
    BSEU_OP_NOP,
    BSEU_OP_JUMP_VIA_POINTER,
    BSEU_OP_CALL_VIA_POINTER,
    BSEU_OP_COMPARE_SKIP_EQUAL,
    BSEU_OP_COMPARE_IMMEDIATE,
    BSEU_OP_SKIP_REG_BIT_CLEAR,
    BSEU_OP_SKIP_REG_BIT_SET,
    BSEU_OP_SKIP_IO_BIT_CLEAR,
    BSEU_OP_SKIP_IO_BIT_SET,
    BSEU_OP_BRANCH_STATUS_BIT_SET,
    BSEU_OP_BRANCH_STATUS_BIT_CLEAR,
    BSEU_OP_BRANCH_SIGNED_GE,
    BSEU_OP_BRANCH_SIGNED_LT,
    BSEU_OP_BRANCH_UNSIGNED_GE,
    BSEU_OP_BRANCH_UNSIGNED_LT,
    BSEU_OP_BRANCH_CARRY_CLEAR,
    BSEU_OP_BRANCH_CARRY_SET,
    BSEU_OP_BRANCH_HALFCARRY_SET,
    BSEU_OP_BRANCH_HALFCARRY_CLEAR,
    BSEU_OP_BRANCH_TRANSFER_SET,
    BSEU_OP_BRANCH_TRANSFER_CLEAR,
    BSEU_OP_BRANCH_OVERFLOW_SET,
    BSEU_OP_BRANCH_OVERFLOW_CLEAR,
    BSEU_OP_BRANCH_IRQ_ON,
    BSEU_OP_BRANCH_IRQ_OFF,
    BSEU_OP_SET_IO_BIT,
    BSEU_OP_CLEAR_IO_BIT,
    BSEU_OP_ROTATE_LEFT_CARRY
  } bseu_op_t;

  // Decoded instruction handed in by the fetch stage
  typedef struct packed {
    logic                      valid;
    bseu_op_t                  op;
    logic [2:0]                bit_sel;
    logic [`BSEU_OFS_W-1:0]    offset;
    logic [`BSEU_DATA_W-1:0]   imm;
    logic [`BSEU_IO_W-1:0]     io_addr;
  } bseu_instr_t;

  // Operand values read by the core for the instruction
  typedef struct packed {
    logic [`BSEU_DATA_W-1:0]   rd_val;
    logic [`BSEU_DATA_W-1:0]   rr_val;
    logic [`BSEU_DATA_W-1:0]   io_val;
    logic [`BSEU_ADDR_W-1:0]   z_ptr;
    logic [`BSEU_ADDR_W-1:0]   pc;
    logic [`BSEU_DATA_W-1:0]   status_flags;
    logic                      next_two_word;
  } bseu_operands_t;

  // Write-back produced when the instruction completes
  typedef struct packed {
    logic                      done;
    logic                      pc_load;
    logic [`BSEU_ADDR_W-1:0]   pc_value;
    logic                      status_we;
    logic [`BSEU_DATA_W-1:0]   status_flags;
    logic                      io_we;
    logic [`BSEU_IO_W-1:0]     io_addr;
    logic [`BSEU_DATA_W-1:0]   io_data;
    logic                      rd_we;
    logic [`BSEU_DATA_W-1:0]   rd_data;
    logic                      push_we;
    logic [`BSEU_ADDR_W-1:0]   push_data;
  } bseu_result_t;

  // Selected bit of a byte
  function automatic logic bseu_bit_of(input logic [`BSEU_DATA_W-1:0] v,
                                       input logic [2:0] sel);
    return v[sel];
  endfunction

  // One-hot mask of a selected bit
  function automatic logic [`BSEU_DATA_W-1:0] bseu_bit_mask(input logic [2:0] sel);
    return `BSEU_BIT_ONE << sel;
  endfunction

endpackage

// ==== bseu_flag_alu.sv ====
// Flag arithmetic for immediate compare and rotate left through carry
`timescale 1ns/100ps
`default_nettype none
`include "bseu_defines.svh"

module bseu_flag_alu (
  input  wire logic [`BSEU_DATA_W-1:0] rd_val_i,
  input  wire logic [`BSEU_DATA_W-1:0] imm_i,
  input  wire logic [`BSEU_DATA_W-1:0] status_i,
  output logic      [`BSEU_DATA_W-1:0] cmp_status_o,
  output logic      [`BSEU_DATA_W-1:0] rot_status_o,
  output logic      [`BSEU_DATA_W-1:0] rot_data_o
);
  import bseu_pkg::*;

  logic [`BSEU_DATA_W-1:0] diff;
  logic                    d7;
  logic                    k7;
  logic                    r7;
  logic                    d3;
  logic                    k3;
  logic                    r3;

  // ----------------------------------------------------------------
  // Compare: difference is discarded, only flags survive
  // ----------------------------------------------------------------
  always_comb begin
    diff = rd_val_i - imm_i;
    d7   = rd_val_i[`BSEU_MSB];
    k7   = imm_i[`BSEU_MSB];
    r7   = diff[`BSEU_MSB];
    d3   = rd_val_i[`BSEU_NIB_MSB];
    k3   = imm_i[`BSEU_NIB_MSB];
    r3   = diff[`BSEU_NIB_MSB];
    // compare flag update
    // S is left alone since only Z N V C H are defined to change
    cmp_status_o              = status_i;
    cmp_status_o[`BSEU_FLAG_Z] = (diff == `BSEU_BYTE_ZERO);
    cmp_status_o[`BSEU_FLAG_N] = r7;
    cmp_status_o[`BSEU_FLAG_V] = (d7 & ~k7 & ~r7) | (~d7 & k7 & r7);
    cmp_status_o[`BSEU_FLAG_C] = (~d7 & k7) | (k7 & r7) | (r7 & ~d7);
    cmp_status_o[`BSEU_FLAG_H] = (~d3 & k3) | (k3 & r3) | (r3 & ~d3);
  end

  // ----------------------------------------------------------------
  // Rotate: carry in at bit 0, old bit 7 out to carry
  // ----------------------------------------------------------------
  always_comb begin
    rot_data_o                 = {rd_val_i[`BSEU_MSB-1:0], status_i[`BSEU_FLAG_C]};
    rot_status_o               = status_i;
    rot_status_o[`BSEU_FLAG_C] = rd_val_i[`BSEU_MSB];
    rot_status_o[`BSEU_FLAG_N] = rd_val_i[`BSEU_MSB-1];
    rot_status_o[`BSEU_FLAG_V] = rd_val_i[`BSEU_MSB-1] ^ rd_val_i[`BSEU_MSB];
    rot_status_o[`BSEU_FLAG_Z] = ({rd_val_i[`BSEU_MSB-1:0], status_i[`BSEU_FLAG_C]}
                                  == `BSEU_BYTE_ZERO);
  end

endmodule
`default_nettype wire

// ==== bseu_cond_eval.sv ====
// Branch condition evaluation against the status flags
`timescale 1ns/100ps
`default_nettype none
`include "bseu_defines.svh"

module bseu_cond_eval (
  input  wire bseu_pkg::bseu_op_t          op_i,
  input  wire logic [`BSEU_DATA_W-1:0]     status_i,
  input  wire logic [2:0]                  bit_sel_i,
  output logic                             is_branch_o,
  output logic                             take_o
);
  import bseu_pkg::*;

  logic f_c;
  logic f_n;
  logic f_v;
  logic f_h;
  logic f_t;
  logic f_i;

  // ----------------------------------------------------------------
  // Condition per branch flavour
  // ----------------------------------------------------------------
  always_comb begin
    f_c         = status_i[`BSEU_FLAG_C];
    f_n         = status_i[`BSEU_FLAG_N];
    f_v         = status_i[`BSEU_FLAG_V];
    f_h         = status_i[`BSEU_FLAG_H];
    f_t         = status_i[`BSEU_FLAG_T];
    f_i         = status_i[`BSEU_FLAG_I];
    is_branch_o = 1'b1;
    take_o      = 1'b0;
    case (op_i)
      BSEU_OP_BRANCH_STATUS_BIT_SET:   take_o = bseu_bit_of(status_i, bit_sel_i);
      BSEU_OP_BRANCH_STATUS_BIT_CLEAR: take_o = ~bseu_bit_of(status_i, bit_sel_i);
      BSEU_OP_BRANCH_SIGNED_GE:        take_o = ~(f_n ^ f_v);
      BSEU_OP_BRANCH_SIGNED_LT:        take_o = f_n ^ f_v;
      BSEU_OP_BRANCH_UNSIGNED_GE:      take_o = ~f_c;
      BSEU_OP_BRANCH_CARRY_CLEAR:      take_o = ~f_c;
      BSEU_OP_BRANCH_UNSIGNED_LT:      take_o = f_c;
      BSEU_OP_BRANCH_CARRY_SET:        take_o = f_c;
      BSEU_OP_BRANCH_HALFCARRY_SET:    take_o = f_h;
      BSEU_OP_BRANCH_HALFCARRY_CLEAR:  take_o = ~f_h;
      BSEU_OP_BRANCH_TRANSFER_SET:     take_o = f_t;
      BSEU_OP_BRANCH_TRANSFER_CLEAR:   take_o = ~f_t;
      BSEU_OP_BRANCH_OVERFLOW_SET:     take_o = f_v;
      BSEU_OP_BRANCH_OVERFLOW_CLEAR:   take_o = ~f_v;
      BSEU_OP_BRANCH_IRQ_ON:           take_o = f_i;
      BSEU_OP_BRANCH_IRQ_OFF:          take_o = ~f_i;
      default:                         is_branch_o = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ==== bseu_exec_unit.sv ====
// Top of the branch, skip and bit execution unit
`timescale 1ns/100ps
`default_nettype none
`include "bseu_defines.svh"

module bseu_exec_unit #(
  parameter int CNT_WIDTH = 2
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    resetn_i,
  input  wire bseu_pkg::bseu_instr_t    instr_i,
  input  wire bseu_pkg::bseu_operands_t operands_i,
  output logic                         ready_o,
  output bseu_pkg::bseu_result_t        result_o
);
  import bseu_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The counter must hold the longest count, three cycles
  // A narrower counter would wrap and end early
  generate
    if (CNT_WIDTH < 2) begin : g_bad_cnt
      $error("CNT_WIDTH must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Types and declarations
  // ----------------------------------------------------------------
  // One-hot codes; others fall to the default branch
  typedef enum logic [1:0] {
    BSEU_ST_IDLE = 2'b01,
    BSEU_ST_BUSY = 2'b10
  } bseu_state_t;

  // Sequencer state; pend_reg parks long write-backs
  bseu_state_t             state_reg;
  bseu_state_t             state_next;
  logic [CNT_WIDTH-1:0]    cnt_reg;
  logic [CNT_WIDTH-1:0]    cnt_next;
  bseu_result_t            pend_reg;
  bseu_result_t            pend_next;

  bseu_result_t            result_reg;
  bseu_result_t            result_next;
  logic                    ready_reg;
  logic                    ready_next;

  // Decode of the presented instruction, not held
  bseu_result_t            exec_res;
  logic [CNT_WIDTH-1:0]    exec_cyc;
  logic                    skip_op;
  logic                    skip_cond;
  logic                    br_is;
  logic                    br_take;
  logic [`BSEU_DATA_W-1:0] cmp_status;
  logic [`BSEU_DATA_W-1:0] rot_status;
  logic [`BSEU_DATA_W-1:0] rot_data;
  logic [`BSEU_ADDR_W-1:0] k_ext;
  logic                    take;

  // ----------------------------------------------------------------
  // Helper instances
  // ----------------------------------------------------------------
  // Condition decode kept apart so the flag map sits in one place
  bseu_cond_eval u_cond (
    .op_i        (instr_i.op),
    .status_i    (operands_i.status_flags),
    .bit_sel_i   (instr_i.bit_sel),
    .is_branch_o (br_is),
    .take_o      (br_take)
  );

  // Flag arithmetic for compare and rotate
  // Both results form every cycle; the case picks one
  bseu_flag_alu u_alu (
    .rd_val_i     (operands_i.rd_val),
    .imm_i        (instr_i.imm),
    .status_i     (operands_i.status_flags),
    .cmp_status_o (cmp_status),
    .rot_status_o (rot_status),
    .rot_data_o   (rot_data)
  );

  // ----------------------------------------------------------------
  // Instruction execution
  // ----------------------------------------------------------------
  // Taken only in idle; operands are sampled on that edge, so the
  // core may change them while the unit counts off the cycles
  // A request seen while busy is dropped, not queued
  assign take = instr_i.valid & (state_reg == BSEU_ST_IDLE);

  // Offset is a signed word count, sign extended to address width
  // PC arithmetic wraps at the top of the space
  assign k_ext = `BSEU_ADDR_W'($signed(instr_i.offset));

  // Result and cycle count of the presented instruction
  // Cycles per group:
  //   jump 2, call 3
  //   compare, rotate 1
  //   I/O bit write 2
  //   branch 1 or 2
  //   skip 1, 2 or 3
  //   other 1, done only
  // Unnamed fields stay zero
  always_comb begin
    exec_res          = '0;
    exec_res.done     = 1'b1;
    exec_res.pc_value = operands_i.pc + `BSEU_PC_STEP;
    exec_cyc          = CNT_WIDTH'(`BSEU_CYC_ONE);
    skip_op           = 1'b0;
    skip_cond         = 1'b0;

    case (instr_i.op)
      BSEU_OP_JUMP_VIA_POINTER: begin
        exec_res.pc_load  = 1'b1;
        exec_res.pc_value = operands_i.z_ptr;
        exec_cyc          = CNT_WIDTH'(`BSEU_CYC_JUMP);
      end

      BSEU_OP_CALL_VIA_POINTER: begin
        exec_res.push_we   = 1'b1;
        exec_res.push_data = operands_i.pc + `BSEU_PC_STEP;
        exec_res.pc_load   = 1'b1;
        exec_res.pc_value  = operands_i.z_ptr;
        exec_cyc           = CNT_WIDTH'(`BSEU_CYC_CALL);
      end

      BSEU_OP_COMPARE_SKIP_EQUAL: begin
        skip_op   = 1'b1;
        skip_cond = (operands_i.rd_val == operands_i.rr_val);
      end

      BSEU_OP_COMPARE_IMMEDIATE: begin
        // Difference itself is never stored
        // flags only, no write-back
        exec_res.status_we    = 1'b1;
        exec_res.status_flags = cmp_status;
      end

      BSEU_OP_SKIP_REG_BIT_CLEAR: begin
        skip_op   = 1'b1;
        skip_cond = ~bseu_bit_of(operands_i.rr_val, instr_i.bit_sel);
      end

      BSEU_OP_SKIP_REG_BIT_SET: begin
        skip_op   = 1'b1;
        skip_cond = bseu_bit_of(operands_i.rr_val, instr_i.bit_sel);
      end

      BSEU_OP_SKIP_IO_BIT_CLEAR: begin
        skip_op   = 1'b1;
        skip_cond = ~bseu_bit_of(operands_i.io_val, instr_i.bit_sel);
      end

      BSEU_OP_SKIP_IO_BIT_SET: begin
        skip_op   = 1'b1;
        skip_cond = bseu_bit_of(operands_i.io_val, instr_i.bit_sel);
      end

      BSEU_OP_SET_IO_BIT: begin
        exec_res.io_we   = 1'b1;
        exec_res.io_addr = instr_i.io_addr;
        exec_res.io_data = operands_i.io_val | bseu_bit_mask(instr_i.bit_sel);
        exec_cyc         = CNT_WIDTH'(`BSEU_CYC_IO_BIT);
      end

      BSEU_OP_CLEAR_IO_BIT: begin
        exec_res.io_we   = 1'b1;
        exec_res.io_addr = instr_i.io_addr;
        exec_res.io_data = operands_i.io_val & ~bseu_bit_mask(instr_i.bit_sel);
        exec_cyc         = CNT_WIDTH'(`BSEU_CYC_IO_BIT);
      end

      BSEU_OP_ROTATE_LEFT_CARRY: begin
        exec_res.rd_we        = 1'b1;
        exec_res.rd_data      = rot_data;
        exec_res.status_we    = 1'b1;
        exec_res.status_flags = rot_status;
      end

      default: begin
        // Untaken branches and unknown codes keep the plain step
        // taken branch reloads PC, two cycles
        if (br_is && br_take) begin
          exec_res.pc_load  = 1'b1;
          exec_res.pc_value = operands_i.pc + k_ext + `BSEU_PC_STEP;
          exec_cyc          = CNT_WIDTH'(`BSEU_CYC_BR_TAKEN);
        end
      end
    endcase
    // A skip overrides the plain step
    // skip length follows next word count
    if (skip_op && skip_cond) begin
      exec_res.pc_load = 1'b1;
      if (operands_i.next_two_word) begin
        exec_res.pc_value = operands_i.pc + `BSEU_SKIP_TWO_STEP;
        exec_cyc          = CNT_WIDTH'(`BSEU_CYC_SKIP_TWO);
      end else begin
        exec_res.pc_value = operands_i.pc + `BSEU_SKIP_ONE_STEP;
        exec_cyc          = CNT_WIDTH'(`BSEU_CYC_SKIP_ONE);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // Write-back strobes are single cycle pulses on the last cycle,
  // so the core commits the instruction exactly once
  // Call walk from take edge 0:
  //   edge 0 ready low
  //   edge 2 done, ready high
  //   edge 3 result zero
  // Next take at edge 3 at the earliest, as result clears
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    pend_next   = pend_reg;
    ready_next  = ready_reg;
    result_next = '0;

    case (state_reg)
      BSEU_ST_IDLE: begin
        // One-cycle work goes straight out
        if (take) begin
          if (exec_cyc == CNT_WIDTH'(`BSEU_CYC_ONE)) begin
            result_next = exec_res;
          end else begin
            pend_next  = exec_res;
            cnt_next   = exec_cyc - CNT_WIDTH'(`BSEU_CYC_ONE);
            state_next = BSEU_ST_BUSY;
            ready_next = 1'b0;
          end
        end
      end

      BSEU_ST_BUSY: begin
        // Count down to the last cycle
        if (cnt_reg == CNT_WIDTH'(`BSEU_CYC_ONE)) begin
          result_next = pend_reg;
          pend_next   = '0;
          cnt_next    = '0;
          state_next  = BSEU_ST_IDLE;
          ready_next  = 1'b1;
        end else begin
          cnt_next = cnt_reg - CNT_WIDTH'(`BSEU_CYC_ONE);
        end
      end

      default: begin
        // Illegal code falls back to idle without a write-back
        pend_next  = '0;
        cnt_next   = '0;
        state_next = BSEU_ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  // Synchronous reset, otherwise plain registering
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg  <= BSEU_ST_IDLE;
      cnt_reg    <= '0;
      pend_reg   <= '0;
      result_reg <= '0;
      ready_reg  <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pend_reg   <= pend_next;
      result_reg <= result_next;
      ready_reg  <= ready_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from flip-flops, no decode glitches
  assign ready_o  = ready_reg;
  assign result_o = result_reg;

endmodule
`default_nettype wire

// ==== bseu_exec_unit_monitor.sv ====
// Checker of the branch, skip and bit execution unit ports
`timescale 1ns/100ps
`default_nettype none

module bseu_exec_unit_monitor #(
  parameter int CNT_WIDTH = 2
) (
  input wire logic                    ref_clk_i,
  input wire logic                    resetn_i,
  input wire bseu_pkg::bseu_instr_t    instr_i,
  input wire bseu_pkg::bseu_operands_t operands_i,
  input wire logic                    ready_o,
  input wire bseu_pkg::bseu_result_t   result_o
);
  import bseu_pkg::*;

  // ----------------------------------------------------------------
  // Request taken
  // ----------------------------------------------------------------
  logic take;
  // A request only counts while the unit is idle
  assign take = instr_i.valid && ready_o;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_jump_two_cycles: assert property (
    take && instr_i.op == BSEU_OP_JUMP_VIA_POINTER |-> ##2 result_o.done && result_o.pc_load
    && result_o.pc_value == $past(operands_i.z_ptr, 2) && !result_o.status_we)
    else $error("pointer jump result wrong");
  a_call_push_return: assert property (
    take && instr_i.op == BSEU_OP_CALL_VIA_POINTER |-> ##3 result_o.done && result_o.push_we
    && result_o.push_data == $past(operands_i.pc, 3) + 16'h0001)
    else $error("pointer call push wrong");
  a_call_busy_span: assert property (
    take && instr_i.op == BSEU_OP_CALL_VIA_POINTER |=> !ready_o [*2] ##1 ready_o)
    else $error("call busy span wrong");
  a_cmpi_zero_flag: assert property (
    take && instr_i.op == BSEU_OP_COMPARE_IMMEDIATE |=> result_o.done && !result_o.rd_we
    && result_o.status_flags[1] == ($past(operands_i.rd_val) == $past(instr_i.imm)))
    else $error("compare zero flag wrong");
  a_rotate_carry_in: assert property (
    take && instr_i.op == BSEU_OP_ROTATE_LEFT_CARRY |=> result_o.rd_we
    && result_o.rd_data == {$past(operands_i.rd_val[6:0]), $past(operands_i.status_flags[0])}
    && result_o.status_flags[0] == $past(operands_i.rd_val[7]))
    else $error("rotate result wrong");
  a_io_bit_set: assert property (
    take && instr_i.op == BSEU_OP_SET_IO_BIT |-> ##2 result_o.io_we && result_o.io_data
    == ($past(operands_i.io_val, 2) | (8'h01 << $past(instr_i.bit_sel, 2))))
    else $error("io bit set data wrong");
  a_branch_taken_late: assert property (
    take && instr_i.op == BSEU_OP_BRANCH_CARRY_SET && operands_i.status_flags[0]
    |=> !result_o.done ##1 result_o.done && result_o.pc_load)
    else $error("taken branch timing wrong");
  a_noskip_one_cycle: assert property (
    take && instr_i.op == BSEU_OP_SKIP_REG_BIT_SET && !operands_i.rr_val[instr_i.bit_sel]
    |=> result_o.done && !result_o.pc_load && result_o.pc_value == $past(operands_i.pc) + 16'h0001)
    else $error("unskipped bit test wrong");
  a_skip_equal_step: assert property (
    take && instr_i.op == BSEU_OP_COMPARE_SKIP_EQUAL && !operands_i.next_two_word
    && operands_i.rd_val == operands_i.rr_val |-> ##2 result_o.done && result_o.pc_load
    && !result_o.status_we && result_o.pc_value == $past(operands_i.pc, 2) + 16'h0002)
    else $error("equal skip result wrong");
  a_result_quiet: assert property (
    !result_o.done |-> result_o == '0)
    else $error("result fields without done");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_call: cover property (take && instr_i.op == BSEU_OP_CALL_VIA_POINTER);
  c_redirect: cover property (result_o.done && result_o.pc_load);
  c_io_write: cover property (result_o.io_we);

endmodule

bind bseu_exec_unit bseu_exec_unit_monitor #(.CNT_WIDTH(CNT_WIDTH)) u_mon (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .instr_i(instr_i),
  .operands_i(operands_i), .ready_o(ready_o), .result_o(result_o));

`default_nettype wire

// ==== bseu_exec_unit_bench.sv ====
// Self-checking bench of the branch, skip and bit execution unit
`timescale 1ns/100ps
`default_nettype none

module bseu_exec_unit_bench;
  import bseu_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------------------------------
  localparam logic [15:0] PC = 16'h0100;
  logic           ref_clk_i = 1'b0;
  logic           resetn_i  = 1'b0;
  bseu_instr_t    ins       = '0;
  bseu_operands_t opd       = '0;
  bseu_result_t   res;
  bseu_result_t   r;
  logic           ready;
  int             error_cnt = 0;
  int             n_tests   = 0;
  int             cyc       = 0;

  // 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;

  bseu_exec_unit #(.CNT_WIDTH(2)) i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .instr_i(ins), .operands_i(opd), .ready_o(ready), .result_o(res));

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Issue one instruction at a falling edge, count cycles to done
  task automatic exec(input bseu_op_t op, input int n, input logic pl, input logic [15:0] pv);
    int c;
    ins.op    = op;
    ins.valid = 1'b1;
    @(negedge ref_clk_i);
    ins.valid = 1'b0;
    c = 1;
    // Bounded wait so a lost done cannot hang the run
    while (res.done !== 1'b1 && c < 6) begin
      @(negedge ref_clk_i);
      c++;
    end
    r = res;
    chk(c == n, "cycle count");
    chk(r.pc_load === pl && r.pc_value === pv, "program counter");
    @(negedge ref_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pointer;
    opd.z_ptr = 16'h2468;
    exec(BSEU_OP_JUMP_VIA_POINTER, 2, 1'b1, 16'h2468);
    chk(r.status_we === 1'b0, "jump touched flags");
    exec(BSEU_OP_CALL_VIA_POINTER, 3, 1'b1, 16'h2468);
    chk(r.push_we === 1'b1 && r.push_data === PC + 16'h0001, "call push");
    $display("pointer test done");
  endtask

  task automatic t_skip;
    opd.rd_val = 8'h5a;
    opd.rr_val = 8'h5a;
    exec(BSEU_OP_COMPARE_SKIP_EQUAL, 2, 1'b1, PC + 16'h0002);
    chk(r.status_we === 1'b0, "skip touched flags");
    opd.next_two_word = 1'b1;
    exec(BSEU_OP_COMPARE_SKIP_EQUAL, 3, 1'b1, PC + 16'h0003);
    opd.rr_val = 8'h10;
    exec(BSEU_OP_COMPARE_SKIP_EQUAL, 1, 1'b0, PC + 16'h0001);
    opd.next_two_word = 1'b0;
    ins.bit_sel = 3'h4;
    exec(BSEU_OP_SKIP_REG_BIT_SET, 2, 1'b1, PC + 16'h0002);
    exec(BSEU_OP_SKIP_REG_BIT_CLEAR, 1, 1'b0, PC + 16'h0001);
    ins.bit_sel = 3'h5;
    exec(BSEU_OP_SKIP_REG_BIT_SET, 1, 1'b0, PC + 16'h0001);
    // Register and I/O bit differ so a wrong source shows
    opd.rr_val = 8'h08;
    opd.io_val = 8'hf7;
    ins.bit_sel = 3'h3;
    opd.next_two_word = 1'b1;
    exec(BSEU_OP_SKIP_IO_BIT_CLEAR, 3, 1'b1, PC + 16'h0003);
    exec(BSEU_OP_SKIP_IO_BIT_SET, 1, 1'b0, PC + 16'h0001);
    opd.next_two_word = 1'b0;
    $display("skip test done");
  endtask

  // Every branch flavour, tested flag clear then set, backward offset
  task automatic t_branch;
    int          fb[16] = '{6, 6, 2, 2, 0, 0, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
    logic [15:0] pol    = 16'h55a9;
    logic        tk;
    ins.offset  = 7'h7e;
    ins.bit_sel = 3'h6;
    for (int i = 0; i < 16; i++) begin
      for (int f = 0; f < 2; f++) begin
        opd.status_flags = f[0] ? 8'h01 << fb[i] : 8'h00;
        tk = (f[0] == pol[i]);
        exec(bseu_op_t'(i + 9), tk ? 2 : 1, tk, tk ? PC - 16'h0001 : PC + 16'h0001);
      end
    end
    $display("branch test done");
  endtask

  task automatic t_flags;
    opd.rd_val = 8'h10;
    ins.imm = 8'h20;
    opd.status_flags = 8'h50;
    exec(BSEU_OP_COMPARE_IMMEDIATE, 1, 1'b0, PC + 16'h0001);
    chk(r.status_we === 1'b1 && r.status_flags === 8'h55 && !r.rd_we, "cmp borrow");
    opd.rd_val = 8'h80;
    ins.imm = 8'h01;
    opd.status_flags = 8'h00;
    exec(BSEU_OP_COMPARE_IMMEDIATE, 1, 1'b0, PC + 16'h0001);
    chk(r.status_flags === 8'h28, "cmp overflow");
    opd.rd_val = 8'h81;
    opd.status_flags = 8'h20;
    exec(BSEU_OP_ROTATE_LEFT_CARRY, 1, 1'b0, PC + 16'h0001);
    chk(r.rd_we === 1'b1 && r.rd_data === 8'h02 && r.status_flags === 8'h29, "rotate");
    opd.rd_val = 8'h80;
    opd.status_flags = 8'h00;
    exec(BSEU_OP_ROTATE_LEFT_CARRY, 1, 1'b0, PC + 16'h0001);
    chk(r.rd_data === 8'h00 && r.status_flags === 8'h0b, "rotate zero");
    $display("flag test done");
  endtask

  task automatic t_iobit;
    opd.io_val = 8'ha5;
    ins.io_addr = 5'h1f;
    ins.bit_sel = 3'h1;
    exec(BSEU_OP_SET_IO_BIT, 2, 1'b0, PC + 16'h0001);
    chk(r.io_we && r.io_addr === 5'h1f && r.io_data === 8'ha7 && !r.status_we, "set");
    ins.bit_sel = 3'h7;
    exec(BSEU_OP_CLEAR_IO_BIT, 2, 1'b0, PC + 16'h0001);
    chk(r.io_we === 1'b1 && r.io_data === 8'h25, "clear io bit");
    $display("io bit test done");
  endtask

  // A request held while busy must be ignored, not queued
  task automatic t_refused;
    opd.z_ptr = 16'h1357;
    ins.op = BSEU_OP_CALL_VIA_POINTER;
    ins.valid = 1'b1;
    @(negedge ref_clk_i);
    ins.op = BSEU_OP_JUMP_VIA_POINTER;
    repeat (2) @(negedge ref_clk_i);
    ins.valid = 1'b0;
    chk(res.done === 1'b1 && res.push_we === 1'b1 && res.pc_value === 16'h1357, "call");
    @(negedge ref_clk_i);
    chk(res.done === 1'b0 && ready === 1'b1, "held request taken");
    $display("refusal test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(ready === 1'b1 && res === '0, "reset state");
    resetn_i = 1'b1;
    opd.pc = PC;
    t_pointer();
    t_skip();
    t_branch();
    t_flags();
    t_iobit();
    t_refused();
    report_and_stop();
  end

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      report_and_stop();
    end
  end

endmodule

`default_nettype wire
